// ==== shared/wiomb_defs.vh ====
// Constants for the wireless I/O holding-register map
// Operation
// - Addresses 01-10 never forwarded over radio
// - Address from tens and units dials
// - Registers 1-4 report discrete inputs
// - Register 8 holds signed temperature code
// - Registers 9,10 hold counter upper, lower
// - Registers 501,502 drive discrete outputs
// - Registers 505,506 drive switched supplies
// - All registers are holding registers
// - No I/O access in transparent mode
`ifndef WIOMB_DEFS_VH
`define WIOMB_DEFS_VH
`define WIOMB_REG_DIN1 16'h0001
`define WIOMB_REG_DIN2 16'h0002
`define WIOMB_REG_DIN3 16'h0003
`define WIOMB_REG_DIN4 16'h0004
`define WIOMB_REG_CL1 16'h0005
`define WIOMB_REG_CL3 16'h0007
`define WIOMB_REG_TEMP 16'h0008
`define WIOMB_REG_CNT_UP 16'h0009
`define WIOMB_REG_CNT_LO 16'h000a
`define WIOMB_REG_DOUT1 16'h01f5
`define WIOMB_REG_DOUT2 16'h01f6
`define WIOMB_REG_SUP3 16'h01f9
`define WIOMB_REG_SUP4 16'h01fa
`define WIOMB_ADDR_LOCAL_MAX 7'h0a
`define WIOMB_ADDR_MIN 7'h01
`define WIOMB_ADDR_MAX 7'h3c
`define WIOMB_OUT_RESET 1'b0
`endif

// ==== hdl/wiomb_addr_dec.v ====
// Slave address forming from two decimal dials and relay decision
`timescale 1ns/100ps
`include "wiomb_defs.vh"
module wiomb_addr_dec (
    input wire [3:0] dial_tens_i,
    input wire [3:0] dial_units_i,
    input wire [6:0] poll_addr_i,
    output wire [6:0] slave_addr_o,
    output wire addr_valid_o,
    output wire relay_ok_o
);
    wire [6:0] tens_x10;
    assign tens_x10 = {dial_tens_i, 3'b000} + {2'b00, dial_tens_i, 1'b0};
    assign slave_addr_o = tens_x10 + {3'b000, dial_units_i};
    assign addr_valid_o = (dial_units_i <= 4'h9) && (slave_addr_o >= `WIOMB_ADDR_MIN)
        && (slave_addr_o <= `WIOMB_ADDR_MAX);
    assign relay_ok_o = (poll_addr_i > `WIOMB_ADDR_LOCAL_MAX);
endmodule // wiomb_addr_dec

// ==== hdl/wiomb_counter.v ====
// 32-bit event counter with lower-word snapshot
`timescale 1ns/100ps
module wiomb_counter #(
    parameter WIDTH = 32
) (
    input wire clk_sys_i,
    input wire reset_i,
    input wire event_i,
    input wire snap_i,
    output reg [WIDTH-1:0] count_q,
    output reg [15:0] lower_snap_q
);
    reg event_prev_q;
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            count_q <= {WIDTH{1'b0}};
            event_prev_q <= 1'b0;
            lower_snap_q <= 16'h0000;
        end else begin
            event_prev_q <= event_i;
            if (event_i && !event_prev_q) begin
                count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
            end
            if (snap_i) begin
                lower_snap_q <= count_q[15:0];
            end
        end
    end
endmodule // wiomb_counter

// ==== hdl/wiomb_regmap.v ====
// Holding-register map for discrete, analog, thermistor, counter and output I/O
`timescale 1ns/100ps
`include "wiomb_defs.vh"
module wiomb_regmap (
    input wire clk_sys_i,
    input wire reset_i,
    input wire transparent_mode_i,
    input wire [3:0] dial_tens_i,
    input wire [3:0] dial_units_i,
    input wire [6:0] poll_addr_i,
    input wire req_valid_i,
    input wire req_write_i,
    input wire [15:0] req_reg_i,
    input wire [15:0] req_wdata_i,
    input wire [3:0] discrete_in_i,
    input wire [15:0] current_loop_1_i,
    input wire [15:0] current_loop_3_i,
    input wire [15:0] temperature_i,
    input wire counter_event_i,
    output reg rsp_valid_o,
    output reg rsp_error_o,
    output reg [15:0] rsp_rdata_o,
    output wire [6:0] slave_addr_o,
    output wire addr_valid_o,
    output wire relay_ok_o,
    output reg discrete_output_1_o,
    output reg discrete_output_2_o,
    output reg switched_supply_3_o,
    output reg switched_supply_4_o
);
    // ----------------------------------------
    // Address and counter
    // ----------------------------------------
    wire [31:0] event_count;
    wire [15:0] lower_snap;
    wire access_ok;
    wire snap_req;
    wiomb_addr_dec u_addr (
        .dial_tens_i(dial_tens_i),
        .dial_units_i(dial_units_i),
        .poll_addr_i(poll_addr_i),
        .slave_addr_o(slave_addr_o),
        .addr_valid_o(addr_valid_o),
        .relay_ok_o(relay_ok_o)
    );
    assign access_ok = req_valid_i && !transparent_mode_i;
    assign snap_req = access_ok && !req_write_i && (req_reg_i == `WIOMB_REG_CNT_UP);
    wiomb_counter #(.WIDTH(32)) u_cnt (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .event_i(counter_event_i),
        .snap_i(snap_req),
        .count_q(event_count),
        .lower_snap_q(lower_snap)
    );

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    reg [15:0] rdata_d;
    reg hit_d;
    always @* begin
        rdata_d = 16'h0000;
        hit_d = 1'b1;
        case (req_reg_i)
            `WIOMB_REG_DIN1: rdata_d = {15'h0000, discrete_in_i[0]};
            `WIOMB_REG_DIN2: rdata_d = {15'h0000, discrete_in_i[1]};
            `WIOMB_REG_DIN3: rdata_d = {15'h0000, discrete_in_i[2]};
            `WIOMB_REG_DIN4: rdata_d = {15'h0000, discrete_in_i[3]};
            `WIOMB_REG_CL1: rdata_d = current_loop_1_i;
            `WIOMB_REG_CL3: rdata_d = current_loop_3_i;
            `WIOMB_REG_TEMP: rdata_d = temperature_i;
            `WIOMB_REG_CNT_UP: rdata_d = event_count[31:16];
            `WIOMB_REG_CNT_LO: rdata_d = lower_snap;
            `WIOMB_REG_DOUT1: rdata_d = {15'h0000, discrete_output_1_o};
            `WIOMB_REG_DOUT2: rdata_d = {15'h0000, discrete_output_2_o};
            `WIOMB_REG_SUP3: rdata_d = {15'h0000, switched_supply_3_o};
            `WIOMB_REG_SUP4: rdata_d = {15'h0000, switched_supply_4_o};
            default: hit_d = 1'b0;
        endcase
    end

    // ----------------------------------------
    // Write and response
    // ----------------------------------------
    always @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rsp_valid_o <= 1'b0;
            rsp_error_o <= 1'b0;
            rsp_rdata_o <= 16'h0000;
            discrete_output_1_o <= `WIOMB_OUT_RESET;
            discrete_output_2_o <= `WIOMB_OUT_RESET;
            switched_supply_3_o <= `WIOMB_OUT_RESET;
            switched_supply_4_o <= `WIOMB_OUT_RESET;
        end else begin
            rsp_valid_o <= req_valid_i;
            rsp_error_o <= req_valid_i && (!access_ok || !hit_d);
            rsp_rdata_o <= (access_ok && !req_write_i) ? rdata_d : 16'h0000;
            if (access_ok && req_write_i) begin
                // Input registers fall through: no effect
                case (req_reg_i)
                    `WIOMB_REG_DOUT1: discrete_output_1_o <= req_wdata_i[0];
                    `WIOMB_REG_DOUT2: discrete_output_2_o <= req_wdata_i[0];
                    `WIOMB_REG_SUP3: switched_supply_3_o <= req_wdata_i[0];
                    `WIOMB_REG_SUP4: switched_supply_4_o <= req_wdata_i[0];
                    default: discrete_output_1_o <= discrete_output_1_o;
                endcase
            end
        end
    end
endmodule // wiomb_regmap

// ==== tb/wiomb_regmap_props.sv ====
// Port checks for the holding-register map
`timescale 1ns/100ps
module wiomb_regmap_props (
    input wire clk_sys_i,
    input wire reset_i,
    input wire transparent_mode_i,
    input wire [6:0] poll_addr_i,
    input wire req_valid_i,
    input wire req_write_i,
    input wire [15:0] req_reg_i,
    input wire [15:0] req_wdata_i,
    input wire [3:0] discrete_in_i,
    input wire rsp_valid_o,
    input wire rsp_error_o,
    input wire [15:0] rsp_rdata_o,
    input wire relay_ok_o,
    input wire discrete_output_1_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    sequence s_rd(n); req_valid_i && !req_write_i && !transparent_mode_i && req_reg_i == n; endsequence
    sequence s_wr(n); req_valid_i && req_write_i && !transparent_mode_i && req_reg_i == n; endsequence
    property p_rsp; req_valid_i |=> rsp_valid_o; endproperty
    a_rsp: assert property (p_rsp) else $error("no response");
    property p_idle; !req_valid_i |=> !rsp_valid_o; endproperty
    a_idle: assert property (p_idle) else $error("stray response");
    property p_trn; req_valid_i && transparent_mode_i |=> rsp_error_o && rsp_rdata_o == 0; endproperty
    a_trn: assert property (p_trn) else $error("access in transparent mode");
    property p_di; s_rd(1) |=> rsp_rdata_o == {15'h0, $past(discrete_in_i[0])}; endproperty
    a_di: assert property (p_di) else $error("bad input read");
    property p_do; s_wr(16'h01f5) |=> discrete_output_1_o == $past(req_wdata_i[0]); endproperty
    a_do: assert property (p_do) else $error("output not written");
    property p_hold; req_valid_i && (req_reg_i != 16'h01f5 || transparent_mode_i) |=> $stable(discrete_output_1_o); endproperty
    a_hold: assert property (p_hold) else $error("output moved");
    property p_ro; s_wr(1) |=> !rsp_error_o && rsp_rdata_o == 0; endproperty
    a_ro: assert property (p_ro) else $error("input write refused");
    property p_rly; relay_ok_o == (poll_addr_i > 7'h0a); endproperty
    a_rly: assert property (p_rly) else $error("bad relay");
endmodule // wiomb_regmap_props

// ==== tb/wiomb_host_model.sv ====
// Host master issuing holding-register polls
`timescale 1ns/100ps
module wiomb_host_model (
    input wire clk_sys_i,
    output logic [33:0] req_o
);
    initial req_o = 34'h0;
    task xfer(input logic w, input logic [15:0] r, input logic [15:0] d);
        @(negedge clk_sys_i) req_o <= {1'b1, w, r, d};
        @(negedge clk_sys_i) req_o <= {1'b0, w, ~r, ~d};
    endtask
endmodule // wiomb_host_model

// ==== tb/wiomb_regmap_tb.sv ====
// Self-checking bench for the holding-register map
`timescale 1ns/100ps
module wiomb_regmap_tb;
    logic clk_sys_i = 0, reset_i = 1, transparent_mode_i = 0, counter_event_i = 0;
    wire req_valid_i, req_write_i, rsp_valid_o, rsp_error_o, addr_valid_o, relay_ok_o;
    wire discrete_output_1_o, discrete_output_2_o, switched_supply_3_o, switched_supply_4_o;
    wire [6:0] slave_addr_o;
    wire [15:0] req_reg_i, req_wdata_i, rsp_rdata_o;
    wire [3:0] outs = {switched_supply_4_o, switched_supply_3_o, discrete_output_2_o, discrete_output_1_o};
    logic [3:0] dial_tens_i = 0, dial_units_i = 0, discrete_in_i = 0;
    logic [6:0] poll_addr_i = 0;
    logic [15:0] current_loop_1_i = 0, current_loop_3_i = 0, temperature_i = 0, d;
    logic [15:0] regs[4] = '{16'h01f5, 16'h01f6, 16'h01f9, 16'h01fa};
    logic [16:0] exp_q[$];
    logic [31:0] seed = 18;
    int checks = 0, n_mismatch = 0, n_relay = 0;
    wiomb_regmap DUT (.*);
    wiomb_host_model u_host (.clk_sys_i, .req_o({req_valid_i, req_write_i, req_reg_i, req_wdata_i}));
    initial forever #10 clk_sys_i = ~clk_sys_i;
    initial begin
        #300000 n_mismatch++;
        test_done;
    end
    function logic [15:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    task chk(input logic [16:0] s, input logic [16:0] e);
        checks++;
        n_mismatch += (s !== e);
        if (s !== e) $display("mismatch %0t got %h exp %h", $time, s, e);
    endtask
    task op(input logic w, input logic [15:0] r, input logic [15:0] d, input logic [16:0] e);
        exp_q.push_back(e);
        u_host.xfer(w, r, d);
    endtask
    task test_done;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(negedge clk_sys_i) begin
        // A response with nothing expected counts as a mismatch
        if (rsp_valid_o === 1'b1) chk({rsp_error_o, rsp_rdata_o}, (exp_q.size() > 0) ? exp_q.pop_front() : 17'h1ffff);
    end
    initial begin
        repeat (3) @(negedge clk_sys_i);
        reset_i = 0;
        for (int i = 0; i < 61; i++) begin
            @(negedge clk_sys_i) {dial_tens_i, dial_units_i, poll_addr_i} = {4'(i / 10), 4'(i % 10), 7'(i)};
            #1 chk({slave_addr_o, relay_ok_o, addr_valid_o}, {7'(i), i > 10, i > 0});
            n_relay += (relay_ok_o === 1'b1);
        end
        chk(17'(n_relay), 17'd50);
        {discrete_in_i, current_loop_1_i, current_loop_3_i, temperature_i} = 52'({rnd(), rnd(), rnd(), rnd()});
        for (int k = 0; k < 4; k++) op(0, k + 1, rnd(), discrete_in_i[k]);
        op(0, 5, 0, current_loop_1_i);
        op(0, 7, 0, current_loop_3_i);
        op(0, 8, 0, temperature_i);
        foreach (regs[k]) repeat (2) begin
            d = rnd();
            op(1, regs[k], d, 0);
            chk(outs[k], d[0]);
            op(0, regs[k], 0, d[0]);
        end
        op(1, 1, 16'hffff, 0);
        op(0, 6, 0, 17'h10000);
        transparent_mode_i = 1;
        op(1, 16'h01f5, 16'hffff, 17'h10000);
        transparent_mode_i = 0;
        repeat (10) @(negedge clk_sys_i) counter_event_i = ~counter_event_i;
        op(0, 9, 0, 0);
        repeat (4) @(negedge clk_sys_i) counter_event_i = ~counter_event_i;
        op(0, 10, 0, 5);
        repeat (2) @(negedge clk_sys_i);
        test_done;
    end
endmodule // wiomb_regmap_tb
bind wiomb_regmap wiomb_regmap_props u_props (.*);
